/* core/pas_pkg.sv */
/*
 Package for the Port A block with pin steering: register map, reset values,
 pin and steering bit positions, and the structs that carry peripheral drives,
 configuration-word enables and steered routes.
 Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
package pas_pkg;

   // Register byte offsets
   localparam logic [7:0] PAS_PIN_VALUE_ADR     = 8'h00;
   localparam logic [7:0] PAS_DIRECTION_ADR     = 8'h04;
   localparam logic [7:0] PAS_OUTPUT_LATCH_ADR  = 8'h08;
   localparam logic [7:0] PAS_ANALOG_SELECT_ADR = 8'h0c;
   localparam logic [7:0] PAS_STEERING_ADR      = 8'h10;

   // Values after reset
   localparam logic [7:0] PAS_DIRECTION_RST     = 8'hff;
   localparam logic [7:0] PAS_OUTPUT_LATCH_RST  = 8'h00;
   localparam logic [5:0] PAS_ANALOG_SELECT_RST = 6'h3f;
   localparam logic [6:0] PAS_STEERING_RST      = 7'h00;

   // Steering bit positions
   localparam int PAS_CAPCOMP2_PIN_CHOICE    = 0;
   localparam int PAS_SLAVE_SELECT_PIN_CHOICE = 1;
   localparam int PAS_COMPARATOR2_PIN_CHOICE = 2;
   localparam int PAS_LATCH_INV_PIN_CHOICE   = 3;
   localparam int PAS_PWM2_B_PIN_CHOICE      = 4;
   localparam int PAS_TIMER1_GATE_PIN_CHOICE = 5;
   localparam int PAS_CAPCOMP3_PIN_CHOICE    = 6;

   // Regulator capacitor pin placement
   localparam logic [1:0] PAS_REGULATOR_CAPACITOR_ON_PIN0 = 2'h0;
   localparam logic [1:0] PAS_REGULATOR_CAPACITOR_ON_PIN5 = 2'h1;
   localparam logic [1:0] PAS_REGULATOR_CAPACITOR_ON_PIN6 = 2'h2;

   // Peripheral output drives toward Port A and steered outputs
   typedef struct packed {
      logic [7:0] lcd_en;      // One LCD segment/common per pin
      logic [7:0] lcd_val;
      logic       lcd_common_three_en;     // Second LCD entry on pin 3
      logic       lcd_common_three_val;
      logic       srq_en;
      logic       srq_val;
      logic       latch_inverted_output_en;
      logic       latch_inverted_output_val;
      logic       c1_en;
      logic       c1_val;
      logic       c2_en;
      logic       c2_val;
      logic       dac_en;
      logic       dac_val;
      logic       capcomp5_signal_en;
      logic       capcomp5_signal_val;
      logic       clock_output_pin_val;
      logic       ccp3_en;
      logic       ccp3_val;
      logic       p2b_en;
      logic       p2b_val;
      logic       ccp2_en;
      logic       ccp2_val;
   } pas_periph_s;

   // Configuration-word enables
   typedef struct packed {
      logic       regulator_capacitor_en;
      logic [1:0] regulator_capacitor_pin;
      logic       osc_ext;     // Oscillator uses pins 6 and 7
      logic       clock_output_pin_en;
      logic       pins28;      // 28-pin package variant
   } pas_cfg_s;

   // One steered output: override enable per candidate pin and value
   typedef struct packed {
      logic prim_en;
      logic alt_en;
      logic val;
   } pas_route_s;

endpackage

/* core/pas_port_a.sv */
/*
 Port A general purpose I/O with pin steering: direction, output latch,
 synchronised pin read-back, analog select gating, steering register and the
 fixed output priority multiplexer of the eight Port A pins.
 Assumes a classic Wishbone master on clk_i, asynchronous pins on pin_in_i,
 and peripheral drives and configuration enables from logic on clk_i.
*/
// Operation
// - Seven steering bits, bit 7 reads zero
// - Steering moves overrides, never touches direction
// - Bit 6 moves capture/compare 3 pin
// - Bit 5 picks timer1 gate source pin
// - Bit 4 moves second PWM B output
// - Bit 3 moves latch inverted output
// - Bit 2 moves comparator 2 output
// - Bit 1 picks slave select source pin
// - Bit 0 moves capture/compare 2 signal
// - Direction one tristates, zero drives latch
// - Pin value reads pins, writes latch
// - Port writes are read-modify-write into latch
// - Direction controls drivers even in analog
// - Analog pins read zero, buffer disabled
// - Analog select leaves digital outputs alone
// - Analog select resets to analog mode
// - Highest enabled function owns the pin
// - Priority order for pins zero to three
// - Priority order for pins four, five
// - Priority order for pins six, seven
// - Analog inputs active only in analog mode
`timescale 1ns/1ps
`default_nettype none

module pas_port_a (
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // Wishbone slave
   input  wire logic               cyc_i,
   input  wire logic               stb_i,
   input  wire logic               we_i,
   input  wire logic [7:0]         adr_i,
   input  wire logic [3:0]         sel_i,
   input  wire logic [31:0]        dat_i,
   output logic      [31:0]        dat_o,
   output logic                    ack_o,
   // Port A pins
   input  wire logic [7:0]         pin_in_i,
   output logic      [7:0]         pin_out_o,
   output logic      [7:0]         pin_oe_o,
   output logic      [7:0]         dig_in_en_o,
   output logic      [7:0]         analog_on_o,
   // Peripherals and configuration
   input  wire pas_pkg::pas_periph_s periph_i,
   input  wire pas_pkg::pas_cfg_s  cfg_i,
   input  wire logic               t1g_rb5_i,
   input  wire logic               t1g_rc4_i,
   // Steered signals
   output pas_pkg::pas_route_s     ccp3_o,
   output pas_pkg::pas_route_s     p2b_o,
   output pas_pkg::pas_route_s     ccp2_o,
   output logic                    timer1_gate_o,
   output logic                    slave_select_o
);
   import pas_pkg::*;

   logic [7:0]  dir_ff;
   logic [7:0]  lat_ff;
   logic [5:0]  ansel_ff;
   logic [6:0]  steer_ff;
   logic        ack_ff;
   logic [31:0] dat_ff;
   pas_cfg_s    cfg_ff;
   logic [7:0]  sync1_ff;
   logic [7:0]  sync2_ff;
   logic [7:0]  sync3_ff;
   logic [7:0]  pin_lvl_ff;
   logic [7:0]  pin_out_ff;
   logic [7:0]  pin_oe_ff;
   logic        t1g_ff;
   logic        ss_ff;
   pas_route_s  ccp3_ff;
   pas_route_s  p2b_ff;
   pas_route_s  ccp2_ff;
   logic [7:0]  ansel_all;
   logic [7:0]  dig_read;
   logic        req;
   logic        wr_now;
   logic [31:0] nxt_dat;
   logic [7:0]  nxt_val;
   logic [7:0]  nxt_hiz;

   assign ansel_all = {2'b00, ansel_ff};
   assign dig_read  = pin_lvl_ff & ~ansel_all;

   // Bus: one wait cycle, writes land on the acknowledge edge
   assign req    = cyc_i & stb_i & ~ack_ff;
   assign wr_now = cyc_i & stb_i & we_i & ack_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req;
      end
   end

   always_comb begin
      nxt_dat = 32'h0000_0000;
      case (adr_i)
         PAS_PIN_VALUE_ADR:     nxt_dat[7:0] = dig_read;
         PAS_DIRECTION_ADR:     nxt_dat[7:0] = dir_ff;
         PAS_OUTPUT_LATCH_ADR:  nxt_dat[7:0] = lat_ff;
         PAS_ANALOG_SELECT_ADR: nxt_dat[5:0] = ansel_ff;
         PAS_STEERING_ADR:      nxt_dat[6:0] = steer_ff;
         default:               nxt_dat = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_ff <= 32'h0000_0000;
      end else if (req) begin
         dat_ff <= nxt_dat;
      end
   end

   // Configuration enables sampled while reset stands, held after it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_ff <= cfg_i;
      end
   end

   // Control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dir_ff <= PAS_DIRECTION_RST;
      end else if (wr_now && sel_i[0] && adr_i == PAS_DIRECTION_ADR) begin
         dir_ff <= dat_i[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ansel_ff <= PAS_ANALOG_SELECT_RST;
      end else if (wr_now && sel_i[0] && adr_i == PAS_ANALOG_SELECT_ADR) begin
         ansel_ff <= dat_i[5:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         steer_ff <= PAS_STEERING_RST;
      end else if (wr_now && sel_i[0] && adr_i == PAS_STEERING_ADR) begin
         steer_ff <= dat_i[6:0];
      end
   end

   // Latch: port writes merge the pin read-back with the addressed lane
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lat_ff <= PAS_OUTPUT_LATCH_RST;
      end else if (wr_now && adr_i == PAS_PIN_VALUE_ADR) begin
         lat_ff <= sel_i[0] ? dat_i[7:0] : dig_read;
      end else if (wr_now && sel_i[0] && adr_i == PAS_OUTPUT_LATCH_ADR) begin
         lat_ff <= dat_i[7:0];
      end
   end

   // Pin synchronisers, a level counts once stages two and three agree
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_sync
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               sync1_ff[g]   <= 1'b0;
               sync2_ff[g]   <= 1'b0;
               sync3_ff[g]   <= 1'b0;
               pin_lvl_ff[g] <= 1'b0;
            end else begin
               sync1_ff[g] <= pin_in_i[g];
               sync2_ff[g] <= sync1_ff[g];
               sync3_ff[g] <= sync2_ff[g];
               if (sync2_ff[g] == sync3_ff[g]) begin
                  pin_lvl_ff[g] <= sync3_ff[g];
               end
            end
         end
      end
   endgenerate

   // Output priority, lowest entry first so higher ones overwrite
   always_comb begin
      nxt_val = lat_ff;
      nxt_hiz = 8'h00;
      // Pin 0
      if (periph_i.c2_en && steer_ff[PAS_COMPARATOR2_PIN_CHOICE]) begin
         nxt_val[0] = periph_i.c2_val;
      end
      if (periph_i.latch_inverted_output_en && steer_ff[PAS_LATCH_INV_PIN_CHOICE]) begin
         nxt_val[0] = periph_i.latch_inverted_output_val;
      end
      if (periph_i.lcd_en[0]) begin
         nxt_val[0] = periph_i.lcd_val[0];
      end
      if (cfg_ff.regulator_capacitor_en && cfg_ff.regulator_capacitor_pin == PAS_REGULATOR_CAPACITOR_ON_PIN0) begin
         nxt_hiz[0] = 1'b1;
      end
      // Pin 1
      if (periph_i.lcd_en[1]) begin
         nxt_val[1] = periph_i.lcd_val[1];
      end
      // Pin 2
      if (periph_i.dac_en) begin
         nxt_val[2] = periph_i.dac_val;
      end
      if (periph_i.lcd_en[2]) begin
         nxt_val[2] = periph_i.lcd_val[2];
      end
      // Pin 3
      if (periph_i.lcd_en[3]) begin
         nxt_val[3] = periph_i.lcd_val[3];
      end
      if (periph_i.lcd_common_three_en && cfg_ff.pins28) begin
         nxt_val[3] = periph_i.lcd_common_three_val;
      end
      // Pin 4
      if (periph_i.capcomp5_signal_en && cfg_ff.pins28) begin
         nxt_val[4] = periph_i.capcomp5_signal_val;
      end
      if (periph_i.c1_en) begin
         nxt_val[4] = periph_i.c1_val;
      end
      if (periph_i.srq_en) begin
         nxt_val[4] = periph_i.srq_val;
      end
      if (periph_i.lcd_en[4]) begin
         nxt_val[4] = periph_i.lcd_val[4];
      end
      // Pin 5
      if (periph_i.c2_en && !steer_ff[PAS_COMPARATOR2_PIN_CHOICE]) begin
         nxt_val[5] = periph_i.c2_val;
      end
      if (periph_i.latch_inverted_output_en && !steer_ff[PAS_LATCH_INV_PIN_CHOICE]) begin
         nxt_val[5] = periph_i.latch_inverted_output_val;
      end
      if (periph_i.lcd_en[5]) begin
         nxt_val[5] = periph_i.lcd_val[5];
      end
      if (cfg_ff.regulator_capacitor_en && cfg_ff.regulator_capacitor_pin == PAS_REGULATOR_CAPACITOR_ON_PIN5) begin
         nxt_hiz[5] = 1'b1;
      end
      // Pin 6
      if (periph_i.lcd_en[6]) begin
         nxt_val[6] = periph_i.lcd_val[6];
      end
      if (cfg_ff.clock_output_pin_en) begin
         nxt_val[6] = periph_i.clock_output_pin_val;
      end
      if (cfg_ff.osc_ext || (cfg_ff.regulator_capacitor_en && cfg_ff.regulator_capacitor_pin == PAS_REGULATOR_CAPACITOR_ON_PIN6)) begin
         nxt_hiz[6] = 1'b1;
      end
      // Pin 7
      if (periph_i.lcd_en[7]) begin
         nxt_val[7] = periph_i.lcd_val[7];
      end
      if (cfg_ff.osc_ext) begin
         nxt_hiz[7] = 1'b1;
      end
   end

   // Pin drivers; analog select deliberately plays no part here
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_out_ff <= 8'h00;
         pin_oe_ff  <= 8'h00;
      end else begin
         pin_out_ff <= nxt_val;
         pin_oe_ff  <= ~dir_ff & ~nxt_hiz;
      end
   end

   // Steered routes and inputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ccp3_ff <= '0;
         p2b_ff  <= '0;
         ccp2_ff <= '0;
      end else begin
         ccp3_ff.prim_en <= periph_i.ccp3_en & ~steer_ff[PAS_CAPCOMP3_PIN_CHOICE];
         ccp3_ff.alt_en  <= periph_i.ccp3_en & steer_ff[PAS_CAPCOMP3_PIN_CHOICE];
         ccp3_ff.val     <= periph_i.ccp3_val;
         p2b_ff.prim_en  <= periph_i.p2b_en & ~steer_ff[PAS_PWM2_B_PIN_CHOICE];
         p2b_ff.alt_en   <= periph_i.p2b_en & steer_ff[PAS_PWM2_B_PIN_CHOICE];
         p2b_ff.val      <= periph_i.p2b_val;
         ccp2_ff.prim_en <= periph_i.ccp2_en & ~steer_ff[PAS_CAPCOMP2_PIN_CHOICE];
         ccp2_ff.alt_en  <= periph_i.ccp2_en & steer_ff[PAS_CAPCOMP2_PIN_CHOICE];
         ccp2_ff.val     <= periph_i.ccp2_val;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         t1g_ff <= 1'b0;
         ss_ff  <= 1'b0;
      end else begin
         t1g_ff <= steer_ff[PAS_TIMER1_GATE_PIN_CHOICE] ? t1g_rc4_i : t1g_rb5_i;
         ss_ff  <= steer_ff[PAS_SLAVE_SELECT_PIN_CHOICE] ? dig_read[0] : dig_read[5];
      end
   end

   assign dat_o          = dat_ff;
   assign ack_o          = ack_ff;
   assign pin_out_o      = pin_out_ff;
   assign pin_oe_o       = pin_oe_ff;
   assign dig_in_en_o    = ~ansel_all;
   assign analog_on_o    = ansel_all;
   assign ccp3_o         = ccp3_ff;
   assign p2b_o          = p2b_ff;
   assign ccp2_o         = ccp2_ff;
   assign timer1_gate_o  = t1g_ff;
   assign slave_select_o = ss_ff;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_steer_top_zero: assert property (
      ack_o && !we_i && adr_i == PAS_STEERING_ADR |-> dat_o[31:7] == 25'h0
   ) else $error("steering top bits not zero");
   chk_steer_keeps_dir: assert property (
      wr_now && adr_i == PAS_STEERING_ADR |=> $stable(dir_ff)
   ) else $error("steering write changed direction");
   chk_ccp3_route: assert property (
      periph_i.ccp3_en && steer_ff[PAS_CAPCOMP3_PIN_CHOICE] |=> ccp3_o.alt_en && !ccp3_o.prim_en
   ) else $error("capture compare 3 not on alternate pin");
   chk_gate_pick: assert property (
      !steer_ff[PAS_TIMER1_GATE_PIN_CHOICE] |=> timer1_gate_o == $past(t1g_rb5_i)
   ) else $error("timer1 gate not from primary pin");
   chk_dir_tristate: assert property (
      dir_ff[2] |=> !pin_oe_o[2]
   ) else $error("input pin still driven");
   chk_latch_drive: assert property (
      !dir_ff[1] && !periph_i.lcd_en[1] |=> pin_oe_o[1] && pin_out_o[1] == $past(lat_ff[1])
   ) else $error("output pin not driving latch");
   chk_analog_read: assert property (
      ack_o && !we_i && adr_i == PAS_PIN_VALUE_ADR |-> (dat_o[5:0] & $past(ansel_ff)) == 6'h00
   ) else $error("analog pin read as one");
   chk_analog_drive: assert property (
      ansel_ff[3] && !dir_ff[3] && !periph_i.lcd_en[3] && !periph_i.lcd_common_three_en |=> pin_oe_o[3]
   ) else $error("analog select stopped digital output");
   chk_pin0_order: assert property (
      periph_i.c2_en && periph_i.latch_inverted_output_en && steer_ff[2] && steer_ff[3] && !periph_i.lcd_en[0]
      |=> pin_out_o[0] == $past(periph_i.latch_inverted_output_val)
   ) else $error("pin 0 priority wrong");
   chk_pin4_order: assert property (
      periph_i.srq_en && !periph_i.lcd_en[4] |=> pin_out_o[4] == $past(periph_i.srq_val)
   ) else $error("pin 4 priority wrong");

   cov_steer_write: cover property (wr_now && adr_i == PAS_STEERING_ADR);
   cov_pin_read: cover property (ack_o && !we_i && adr_i == PAS_PIN_VALUE_ADR);
   cov_port_rmw: cover property (wr_now && adr_i == PAS_PIN_VALUE_ADR && !sel_i[0]);

endmodule

`default_nettype wire

/* verification/pas_pin_model.sv */
/*
 Pin-side model of Port A: resolves the level seen on each pad from the
 block's driver, an outside driver and a floating pad.
 Assumes the bench changes the outside drive only after clock edges.
*/
`timescale 1ns/1ps
`default_nettype none

module pas_pin_model (
   // Clock
   input  wire logic       clk_i,
   // Port A drivers
   input  wire logic [7:0] pin_out_i,
   input  wire logic [7:0] pin_oe_i,
   // Outside drivers
   input  wire logic [7:0] ext_en_i,
   input  wire logic [7:0] ext_val_i,
   output logic      [7:0] pin_lvl_o
);
   logic [7:0] float_ff = 8'h55;

   // Undriven pads wander, never hold a stale level
   always_ff @(posedge clk_i) begin
      float_ff <= ~float_ff;
   end

   // Outside source only where the block leaves the pad free
   assign pin_lvl_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_en_i & ext_val_i)
                    | (~pin_oe_i & ~ext_en_i & float_ff);
endmodule

`default_nettype wire

/* verification/testbench.sv */
/*
 Self-checking bench for the Port A block: register table, drivers,
 analog gating, read-modify-write, steering and output priority.
 Assumes the block answers each Wishbone request with one ack pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import pas_pkg::*;
   typedef struct packed {logic we; logic [7:0] adr; logic [7:0] wd; logic [7:0] exp;} pas_row_s;
   logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, rb5 = 1'b1, rc4 = 1'b0;
   logic        gate, ss;
   logic [7:0]  adr = 8'h00, pin_lvl, pin_out, pin_oe, dig_en, ana_on, ext_en = 8'hff, ext_val = 8'hc0;
   logic [3:0]  sel = 4'h1;
   logic [31:0] dat_w = 32'h0000_0000, dat_r;
   logic [7:0]  rdat;
   pas_periph_s periph = '0;
   pas_cfg_s    cfg = '0;
   pas_route_s  ccp3, p2b, ccp2;
   int          errors = 0, tests_run = 0, cycles = 0;
   pas_row_s    rows [12] = '{{1'b0, 8'h00, 8'h00, 8'hc0}, {1'b0, 8'h04, 8'h00, 8'hff},
      {1'b0, 8'h08, 8'h00, 8'h00}, {1'b0, 8'h0c, 8'h00, 8'h3f}, {1'b0, 8'h10, 8'h00, 8'h00},
      {1'b1, 8'h10, 8'hff, 8'h7f}, {1'b1, 8'h10, 8'h00, 8'h00}, {1'b1, 8'h04, 8'h5a, 8'h5a},
      {1'b1, 8'h08, 8'ha5, 8'ha5}, {1'b1, 8'h0c, 8'hff, 8'h3f}, {1'b1, 8'h0c, 8'h00, 8'h00},
      {1'b1, 8'h14, 8'hff, 8'h00}};

   pas_port_a dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .pin_in_i(pin_lvl), .pin_out_o(pin_out),
      .pin_oe_o(pin_oe), .dig_in_en_o(dig_en), .analog_on_o(ana_on), .periph_i(periph), .cfg_i(cfg),
      .t1g_rb5_i(rb5), .t1g_rc4_i(rc4), .ccp3_o(ccp3), .p2b_o(p2b), .ccp2_o(ccp2),
      .timer1_gate_o(gate), .slave_select_o(ss));

   pas_pin_model pins (.clk_i(clk), .pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_en_i(ext_en),
      .ext_val_i(ext_val), .pin_lvl_o(pin_lvl));

   initial begin
      forever #12.5 clk = ~clk;
   end

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         stop_test();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One classic cycle, entered just after a rising edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [7:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat_w <= {24'h00_0000, d};
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rdat = dat_r[7:0];
      chk(dat_r[31:24], 8'h00);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, 4'h1, d);
   endtask

   task automatic rd(input logic [7:0] a);
      wb(1'b0, a, 4'h1, 8'h00);
   endtask

   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask

   initial begin
      hold(5);
      rst <= 1'b0;
      @(posedge clk);
      // Pin read-back needs the synchroniser filled first
      hold(4);
      foreach (rows[i]) begin
         if (rows[i].we) wr(rows[i].adr, rows[i].wd);
         rd(rows[i].adr);
         chk(rdat, rows[i].exp);
      end
      // Drive the latch out, then leave analog outputs driving
      ext_en <= 8'h00;
      wr(PAS_OUTPUT_LATCH_ADR, 8'h3c);
      wr(PAS_DIRECTION_ADR, 8'h00);
      hold(6);
      chk(pin_oe, 8'hff);
      chk(pin_out, 8'h3c);
      rd(PAS_PIN_VALUE_ADR);
      chk(rdat, 8'h3c);
      wr(PAS_ANALOG_SELECT_ADR, 8'h3f);
      hold(6);
      chk(pin_oe, 8'hff);
      chk(pin_out, 8'h3c);
      chk(dig_en, 8'hc0);
      chk(ana_on, 8'h3f);
      rd(PAS_PIN_VALUE_ADR);
      chk(rdat, 8'h00);
      wr(PAS_DIRECTION_ADR, 8'hff);
      hold(2);
      chk(pin_oe, 8'h00);
      // Port write with no lane stores the read-back
      wr(PAS_ANALOG_SELECT_ADR, 8'h00);
      ext_en <= 8'hff;
      ext_val <= 8'h96;
      hold(6);
      wb(1'b1, PAS_PIN_VALUE_ADR, 4'h0, 8'h00);
      rd(PAS_OUTPUT_LATCH_ADR);
      chk(rdat, 8'h96);
      wr(PAS_PIN_VALUE_ADR, 8'h20);
      rd(PAS_OUTPUT_LATCH_ADR);
      chk(rdat, 8'h20);
      ext_en <= 8'h00;
      wr(PAS_DIRECTION_ADR, 8'h00);
      periph <= '{ccp3_en: 1'b1, ccp3_val: 1'b1, p2b_en: 1'b1, p2b_val: 1'b1, ccp2_en: 1'b1,
         ccp2_val: 1'b1, default: '0};
      for (int s = 0; s < 2; s++) begin
         wr(PAS_STEERING_ADR, s ? 8'h73 : 8'h00);
         hold(6);
         chk({5'h00, ccp3}, {5'h00, s == 0, s == 1, 1'b1});
         chk({5'h00, p2b}, {5'h00, s == 0, s == 1, 1'b1});
         chk({5'h00, ccp2}, {5'h00, s == 0, s == 1, 1'b1});
         chk({7'h00, gate}, {7'h00, s == 0});
         chk({7'h00, ss}, {7'h00, s == 0});
         rd(PAS_DIRECTION_ADR);
         chk(rdat, 8'h00);
      end
      // Output priority on shared pins
      wr(PAS_OUTPUT_LATCH_ADR, 8'h35);
      wr(PAS_STEERING_ADR, 8'h0c);
      periph.c2_en <= 1'b1;
      hold(2);
      chk(pin_out, 8'h34);
      periph.latch_inverted_output_en <= 1'b1;
      periph.latch_inverted_output_val <= 1'b1;
      hold(2);
      chk(pin_out, 8'h35);
      periph.lcd_en[0] <= 1'b1;
      hold(2);
      chk(pin_out, 8'h34);
      periph.latch_inverted_output_val <= 1'b0;
      wr(PAS_STEERING_ADR, 8'h00);
      hold(2);
      chk(pin_out, 8'h14);
      periph.c1_en <= 1'b1;
      periph.c1_val <= 1'b1;
      periph.srq_en <= 1'b1;
      periph.dac_en <= 1'b1;
      periph.dac_val <= 1'b1;
      periph.lcd_en[2] <= 1'b1;
      hold(2);
      chk(pin_out, 8'h00);
      // Second reset with configuration enables
      cfg <= '{regulator_capacitor_en: 1'b1, regulator_capacitor_pin: PAS_REGULATOR_CAPACITOR_ON_PIN0, clock_output_pin_en: 1'b1, pins28: 1'b1, default: '0};
      rst <= 1'b1;
      hold(5);
      chk({7'h00, ack}, 8'h00);
      chk(pin_oe, 8'h00);
      rst <= 1'b0;
      @(posedge clk);
      periph <= '{lcd_en: 8'h48, clock_output_pin_val: 1'b1, lcd_common_three_en: 1'b1, lcd_common_three_val: 1'b1, default: '0};
      wr(PAS_DIRECTION_ADR, 8'h00);
      hold(2);
      chk(pin_oe, 8'hfe);
      chk(pin_out & 8'h48, 8'h48);
      // Third reset: capacitor on pin 5, external oscillator, 28-pin entry on pin 4
      cfg <= '{regulator_capacitor_en: 1'b1, regulator_capacitor_pin: PAS_REGULATOR_CAPACITOR_ON_PIN5, osc_ext: 1'b1, pins28: 1'b1, default: '0};
      rst <= 1'b1;
      hold(5);
      rst <= 1'b0;
      @(posedge clk);
      periph <= '{capcomp5_signal_en: 1'b1, capcomp5_signal_val: 1'b1, default: '0};
      wr(PAS_DIRECTION_ADR, 8'h00);
      hold(2);
      chk(pin_oe, 8'h1f);
      chk(pin_out & 8'h10, 8'h10);
      stop_test();
   end
endmodule

`default_nettype wire
